// *** hdl/wdsc_regs.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef WDSC_REGS_SVH
`define WDSC_REGS_SVH

// Register byte offsets on the plain register port
`define WDSC_OFS_OPTION 8'h00
`define WDSC_OFS_FUSE 8'h04
`define WDSC_OFS_STATUS 8'h08
`define WDSC_OFS_GIE 8'h0c
`define WDSC_OFS_IRQ_EN 8'h10

// Prescaler config fields and reset value
`define WDSC_OPT_RESET 8'hff
`define WDSC_OPT_PSA_BIT 3
`define WDSC_OPT_PS_MSB 2

// Fuse word fields
`define WDSC_FUSE_WATCHDOG_ENABLE_FUSE_BIT 3
`define WDSC_FUSE_OSC_MSB 2

// Clock source codes in the fuse word
`define WDSC_OSC_LP 3'h0
`define WDSC_OSC_XT 3'h1
`define WDSC_OSC_HS 3'h2

// Status register fields
`define WDSC_ST_PD_BIT 0
`define WDSC_ST_TO_BIT 1
`define WDSC_ST_SLEEP_BIT 2
`define WDSC_ST_OST_BIT 3

// Global enable bit and interrupt source bits
`define WDSC_GIE_BIT 0
`define WDSC_INT_PIN_BIT 0
`define WDSC_WAKE_CAPABLE 8'h7f

// Interrupt vector taken after an enabled wake
`define WDSC_VECTOR_ADDR 13'h0004

// Timing: core clock rate, watchdog base period, start-up delay
`define WDSC_CLK_MHZ 200
`define WDSC_WDT_BASE_US 18000
`define WDSC_OST_PERIODS 1024
`define WDSC_BASE_W 22
`define WDSC_OST_W 11

`endif

// *** hdl/wdsc_pkg.sv ***
// Types shared by the watchdog and sleep control block
package wdsc_pkg;
    // Power state of the core as seen by this block
    typedef enum logic [1:0] {
        WDSC_RUN,
        WDSC_SLEEP,
        WDSC_OST_WAIT
    } wdsc_state_t;

    // Register bus widths
    typedef logic [7:0] wdsc_addr_t;
    typedef logic [7:0] wdsc_data_t;
endpackage

// *** hdl/wdsc_core.sv ***
// Watchdog timer, shared prescaler and sleep / wake-up control
//
// Local design decisions: the placing of the registers and the strobed register port.
`include "wdsc_regs.svh"

module wdsc_core #(
    parameter logic [`WDSC_BASE_W-1:0] WDT_BASE_CYCLES =
        `WDSC_BASE_W'(`WDSC_WDT_BASE_US * `WDSC_CLK_MHZ) // Base period
) (
    input wire logic core_clk, // 200 MHz clock
    input wire logic rst_n, // Asynchronous power-on reset
    input wire wdsc_pkg::wdsc_addr_t reg_addr, // Register byte address
    input wire wdsc_pkg::wdsc_data_t reg_wdata, // Register write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output wdsc_pkg::wdsc_data_t reg_rdata, // Read data, next cycle
    input wire logic [7:0] fuse_word, // Configuration word strap
    input wire logic clear_instr, // Watchdog clear instruction
    input wire logic sleep_instr, // Sleep instruction executed
    input wire logic osc_fail, // Oscillator failure detected
    input wire logic external_reset_pin_n, // External reset pin
    input wire logic [7:0] irq_flag, // Interrupt flags, bit0 INT pin
    input wire logic timer0_src_tick, // Timer0 count source pulse
    output logic timer0_tick, // Prescaled Timer0 increment
    output logic device_reset_req, // Internal device reset pulse
    output logic osc_driver_en, // Main oscillator driver on
    output logic core_run, // Core may fetch and execute
    output logic io_hold, // IO pins frozen in last state
    output logic prefetch_req, // Fetch instruction after sleep
    output logic resume_pulse, // Resume after wake-up
    output logic vector_req, // Vector after next instruction
    output logic [12:0] vector_addr // Interrupt vector address
);
    import wdsc_pkg::*;

    wdsc_state_t state_reg; // Power state
    wdsc_state_t state_next; // Next power state
    logic [7:0] option_reg; // Prescaler config
    logic [7:0] fuse_reg; // Captured fuse word
    logic fuse_cap_reg; // Fuse word has been caught
    logic gie_reg; // Global interrupt enable
    logic [7:0] irq_en_reg; // Individual interrupt enables
    logic [7:0] wake_en_reg; // Enables frozen at sleep entry
    logic to_n_reg; // Timeout flag, active low
    logic pd_n_reg; // Powerdown flag, active low
    logic [`WDSC_BASE_W-1:0] base_cnt_reg; // Watchdog base divider
    logic [7:0] presc_reg; // Shared prescaler
    logic [`WDSC_OST_W-1:0] ost_cnt_reg; // Start-up timer
    logic wake_irq_reg; // Last wake came from interrupt
    logic wdt_en; // Watchdog enabled by fuse
    logic prescaler_assign; // Prescaler assigned to watchdog
    logic crystal; // Crystal or resonator clock
    logic pending; // Enabled flag already set
    logic wake_src; // Enabled wake-capable source
    logic sleep_take; // Sleep really executes
    logic sleep_nop; // Sleep degrades to a no-op
    logic base_wrap; // Base period elapsed
    logic wdt_expire; // Watchdog time-out
    logic wdt_clear; // Hold watchdog cleared
    logic wake_now; // Leaving sleep this cycle
    logic wake_by_wdt; // Wake cause is the watchdog
    logic ost_done; // Start-up timer finished
    logic resume; // Core starts executing again
    logic ext_rst; // External reset pin asserted

    // Mask of prescaler bits that must be all ones for one output tick
    function automatic logic [7:0] ratio_mask(input logic [2:0] ps,
                                              input logic to_wdt);
        logic [8:0] full;
        full = 9'h001 << ps;
        if (!to_wdt) begin
            // Timer0 ratios start at 1:2
            full = full << 1;
        end
        ratio_mask = 8'(full - 9'h001);
    endfunction

    // Decoded configuration
    assign prescaler_assign = option_reg[`WDSC_OPT_PSA_BIT];
    assign wdt_en = fuse_cap_reg & fuse_reg[`WDSC_FUSE_WATCHDOG_ENABLE_FUSE_BIT];
    assign crystal = fuse_cap_reg &
        (fuse_reg[`WDSC_FUSE_OSC_MSB:0] == `WDSC_OSC_LP ||
         fuse_reg[`WDSC_FUSE_OSC_MSB:0] == `WDSC_OSC_XT ||
         fuse_reg[`WDSC_FUSE_OSC_MSB:0] == `WDSC_OSC_HS);
    assign ext_rst = ~external_reset_pin_n;

    assign pending = |(irq_flag & irq_en_reg);
    assign sleep_nop = (state_reg == WDSC_RUN) & sleep_instr &
        ~gie_reg & pending;
    assign sleep_take = (state_reg == WDSC_RUN) & sleep_instr &
        ~sleep_nop & ~ext_rst;

    // only clock-free sources can wake, gated by their enables
    // enables are the ones frozen at sleep entry
    assign wake_src = |(irq_flag & wake_en_reg & `WDSC_WAKE_CAPABLE);

    // base divider runs in run and sleep; held at zero during the start-up wait
    assign base_wrap = base_cnt_reg == WDT_BASE_CYCLES - 1'b1;
    // with prescaler, expire after 2^ps base periods
    assign wdt_expire = wdt_en & ~wdt_clear & base_wrap &
        (~prescaler_assign | ((presc_reg & ratio_mask(option_reg[2:0], 1'b1)) ==
                 ratio_mask(option_reg[2:0], 1'b1)));

    // timeout in sleep is a wake cause
    assign wake_by_wdt = (state_reg == WDSC_SLEEP) & wdt_en & base_wrap &
        (~prescaler_assign | ((presc_reg & ratio_mask(option_reg[2:0], 1'b1)) ==
                 ratio_mask(option_reg[2:0], 1'b1)));
    // watchdog or interrupt wake continues execution
    assign wake_now = (state_reg == WDSC_SLEEP) & ~ext_rst &
        (wake_by_wdt | wake_src);
    assign ost_done = ost_cnt_reg == `WDSC_OST_W'(`WDSC_OST_PERIODS - 1);
    assign resume = (wake_now & ~crystal) |
        ((state_reg == WDSC_OST_WAIT) & ost_done & ~ext_rst);

    // Conditions that keep the watchdog at zero
    always_comb begin
        wdt_clear = 1'b0;
        if (!wdt_en || osc_fail || ext_rst) begin
            wdt_clear = 1'b1;
        end
        // clear instruction and sleep both clear
        if ((state_reg == WDSC_RUN) && (clear_instr || sleep_take)) begin
            wdt_clear = 1'b1;
        end
        if (wake_now) begin
            wdt_clear = 1'b1;
        end
        if (state_reg == WDSC_OST_WAIT) begin
            wdt_clear = 1'b1;
        end
    end

    // Power state transitions
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            WDSC_RUN: begin
                if (sleep_take) begin
                    state_next = WDSC_SLEEP;
                end
            end
            WDSC_SLEEP: begin
                // reset pin ends sleep with a reset
                if (ext_rst) begin
                    state_next = WDSC_RUN;
                end else if (wake_now) begin
                    state_next = crystal ? WDSC_OST_WAIT : WDSC_RUN;
                end
            end
            WDSC_OST_WAIT: begin
                if (ext_rst || ost_done) begin
                    state_next = WDSC_RUN;
                end
            end
        endcase
    end

    // Power state register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= WDSC_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // Fuse word is a strap: caught on the first edge after release
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fuse_reg <= 8'h00;
            fuse_cap_reg <= 1'b0;
        end else if (!fuse_cap_reg) begin
            fuse_reg <= fuse_word;
            fuse_cap_reg <= 1'b1;
        end
    end

    // Software registers; writes are accepted in every power state, sleep included
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            option_reg <= `WDSC_OPT_RESET;
            gie_reg <= 1'b0;
            irq_en_reg <= 8'h00;
        end else if (ext_rst) begin
            // Reset pin restores the control defaults
            option_reg <= `WDSC_OPT_RESET;
            gie_reg <= 1'b0;
            irq_en_reg <= 8'h00;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `WDSC_OFS_OPTION: option_reg <= reg_wdata;
                `WDSC_OFS_GIE: gie_reg <= reg_wdata[`WDSC_GIE_BIT];
                `WDSC_OFS_IRQ_EN: irq_en_reg <= reg_wdata;
                default: begin
                    // Read-only and unmapped writes are ignored
                end
            endcase
        end
    end

    // Enables snapshot taken as sleep begins
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_en_reg <= 8'h00;
        end else if (sleep_take) begin
            // later enable changes cannot add wake sources
            wake_en_reg <= irq_en_reg;
        end
    end

    // Read data, valid only in the cycle after the read strobe
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `WDSC_OFS_OPTION: reg_rdata <= option_reg;
                `WDSC_OFS_FUSE: reg_rdata <= fuse_reg;
                `WDSC_OFS_STATUS: reg_rdata <= {4'h0,
                    state_reg == WDSC_OST_WAIT,
                    state_reg == WDSC_SLEEP, to_n_reg, pd_n_reg};
                `WDSC_OFS_GIE: reg_rdata <= {7'h00, gie_reg};
                `WDSC_OFS_IRQ_EN: reg_rdata <= irq_en_reg;
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Watchdog base divider, stands in for the separate RC oscillator
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            base_cnt_reg <= '0;
        end else if (wdt_clear || base_wrap) begin
            base_cnt_reg <= '0;
        end else begin
            base_cnt_reg <= base_cnt_reg + 1'b1;
        end
    end

    // Shared prescaler, counting watchdog periods or Timer0 source
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            presc_reg <= 8'h00;
        end else if (prescaler_assign) begin
            // only cleared with the watchdog while assigned to it
            if (wdt_clear || wdt_expire || wake_by_wdt) begin
                presc_reg <= 8'h00;
            end else if (base_wrap) begin
                presc_reg <= presc_reg + 8'h01;
            end
        end else if (timer0_src_tick) begin
            // Timer0 owns the prescaler when not assigned
            presc_reg <= presc_reg + 8'h01;
        end
    end

    // Prescaled Timer0 increment pulse
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer0_tick <= 1'b0;
        end else begin
            // ratio from the select bits, bypass when assigned away
            timer0_tick <= timer0_src_tick & (prescaler_assign |
                ((presc_reg & ratio_mask(option_reg[2:0], 1'b0)) ==
                 ratio_mask(option_reg[2:0], 1'b0)));
        end
    end

    // Oscillator start-up timer, crystal modes only
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ost_cnt_reg <= '0;
        end else if (state_reg == WDSC_OST_WAIT) begin
            ost_cnt_reg <= ost_cnt_reg + 1'b1;
        end else begin
            ost_cnt_reg <= '0;
        end
    end

    // Status flags; a sleep in the same cycle as a timeout wins for TO
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            to_n_reg <= 1'b1;
            pd_n_reg <= 1'b1;
        end else begin
            if (sleep_take) begin
                pd_n_reg <= 1'b0;
                to_n_reg <= 1'b1;
            end
            // any timeout clears the timeout flag
            if (wdt_expire || wake_by_wdt) begin
                to_n_reg <= 1'b0;
            end
            // a no-op sleep leaves both flags alone
        end
    end

    // Remember why the core woke, for the resume actions
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_irq_reg <= 1'b0;
        end else if (wake_now) begin
            // interrupt wake needs only individual enables
            wake_irq_reg <= wake_src & ~wake_by_wdt;
        end
    end

    // Device reset request, never drives the reset pin
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            device_reset_req <= 1'b0;
        end else begin
            // internal reset only, pin is an input here
            device_reset_req <= ((state_reg == WDSC_RUN) & wdt_expire) |
                ((state_reg == WDSC_SLEEP) & ext_rst);
        end
    end

    // Clock, core and pin controls follow the power state
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_driver_en <= 1'b1;
            core_run <= 1'b1;
            io_hold <= 1'b0;
        end else begin
            // oscillator off and pins frozen while asleep
            osc_driver_en <= state_next != WDSC_SLEEP;
            core_run <= state_next == WDSC_RUN;
            io_hold <= state_next == WDSC_SLEEP;
        end
    end

    // Instruction after sleep is fetched as sleep executes
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prefetch_req <= 1'b0;
        end else begin
            // prefetch on sleep, real or no-op
            prefetch_req <= sleep_take | sleep_nop;
        end
    end

    // Resume and vector requests after a wake-up
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            resume_pulse <= 1'b0;
            vector_req <= 1'b0;
            vector_addr <= 13'h0000;
        end else begin
            // watchdog and interrupt wakes continue the program
            resume_pulse <= resume;
            // vector only with global enable set
            // a late flag still finishes sleep then wakes
            vector_req <= resume & gie_reg &
                (state_reg == WDSC_SLEEP ? wake_src & ~wake_by_wdt
                                         : wake_irq_reg);
            vector_addr <= `WDSC_VECTOR_ADDR;
        end
    end

endmodule // wdsc_core

// *** verification/wdsc_core_props.sv ***
// Port-level assertions for the watchdog and sleep control block
`include "wdsc_regs.svh"
module wdsc_core_props #(
    parameter logic [`WDSC_BASE_W-1:0] WDT_BASE_CYCLES = 16 // Base period
) (
    input wire logic core_clk, // Core clock
    input wire logic rst_n, // Power-on reset
    input wire logic [7:0] fuse_word, // Config strap
    input wire logic sleep_instr, // Sleep instruction
    input wire logic external_reset_pin_n, // Reset pin
    input wire logic device_reset_req, // Internal reset pulse
    input wire logic osc_driver_en, // Oscillator driver
    input wire logic core_run, // Core running
    input wire logic io_hold, // IO frozen
    input wire logic prefetch_req, // Prefetch pulse
    input wire logic resume_pulse, // Resume pulse
    input wire logic vector_req, // Vector pulse
    input wire logic [12:0] vector_addr // Vector address
);
    // One clock domain, so clocking and reset are stated once
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_nap;
        $fell(core_run) |-> io_hold && !osc_driver_en && $past(sleep_instr);
    endproperty
    a_nap: assert property (p_nap)
        else $error("core stopped without a full sleep entry");
    property p_resume;
        resume_pulse |-> core_run && !io_hold && !$past(core_run);
    endproperty
    a_resume: assert property (p_resume)
        else $error("resume pulse outside a wake from sleep");
    property p_vreq;
        vector_req |-> resume_pulse;
    endproperty
    a_vreq: assert property (p_vreq)
        else $error("vector request without resume");
    property p_rstpulse;
        device_reset_req |=> !device_reset_req;
    endproperty
    a_rstpulse: assert property (p_rstpulse)
        else $error("reset request longer than one cycle");
    // Asleep, only the pin may reset; the watchdog must wake instead
    property p_rstcause;
        device_reset_req |-> $past(core_run) || !$past(external_reset_pin_n);
    endproperty
    a_rstcause: assert property (p_rstcause)
        else $error("reset request issued while asleep");
    property p_pin;
        !external_reset_pin_n |=> core_run && !io_hold;
    endproperty
    a_pin: assert property (p_pin)
        else $error("reset pin did not return core to run");
    property p_prefetch;
        sleep_instr && core_run |=> prefetch_req;
    endproperty
    a_prefetch: assert property (p_prefetch)
        else $error("no prefetch after sleep instruction");
    // Crystal modes keep the core stopped for the first 8 cycles after the oscillator driver turns back on
    property p_xtal;
        $rose(osc_driver_en) && fuse_word[2:0] < 3'h3 &&
            $past(external_reset_pin_n) |-> !core_run [*8];
    endproperty
    a_xtal: assert property (p_xtal)
        else $error("core resumed before start-up delay");
    property p_vec;
        $past(rst_n) |-> vector_addr == `WDSC_VECTOR_ADDR;
    endproperty
    a_vec: assert property (p_vec)
        else $error("interrupt vector address wrong");
endmodule // wdsc_core_props

bind wdsc_core wdsc_core_props #(.WDT_BASE_CYCLES(WDT_BASE_CYCLES)) i_props (
    .core_clk(core_clk), .rst_n(rst_n), .fuse_word(fuse_word),
    .sleep_instr(sleep_instr), .external_reset_pin_n(external_reset_pin_n),
    .device_reset_req(device_reset_req), .osc_driver_en(osc_driver_en),
    .core_run(core_run), .io_hold(io_hold), .prefetch_req(prefetch_req),
    .resume_pulse(resume_pulse), .vector_req(vector_req),
    .vector_addr(vector_addr)
);

// *** verification/wdsc_core_tb.sv ***
// Self-checking bench for the watchdog and sleep control block
`include "wdsc_regs.svh"
module wdsc_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import wdsc_pkg::*;
    localparam int BASE = 16; // Short base period keeps the run brief
    logic core_clk = 0, rst_n = 0; // Clock and power-on reset
    wdsc_addr_t reg_addr = 8'h00; // Register address
    wdsc_data_t reg_wdata = 8'h00, reg_rdata; // Register data
    logic reg_wr = 0, reg_rd = 0, clear_instr = 0, sleep_instr = 0;
    logic osc_fail = 0, ext_n = 1, t0_src = 0; // Side inputs
    logic [7:0] fuse_word = 8'h0b, irq_flag = 8'h00; // Strap and flags
    logic t0_tick, rst_req, osc_en, core_run, io_hold, prefetch;
    logic resume, vec_req; // Wake outputs
    logic [12:0] vec_addr; // Vector address
    int err_total = 0, comparisons = 0, cyc = 0, resets = 0, ticks = 0;
    int seed, n, n0, b, p, i, r0; // Scenario scratch

    wdsc_core #(.WDT_BASE_CYCLES(`WDSC_BASE_W'(BASE))) i_dut (
        .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .fuse_word(fuse_word),
        .clear_instr(clear_instr), .sleep_instr(sleep_instr),
        .osc_fail(osc_fail), .external_reset_pin_n(ext_n),
        .irq_flag(irq_flag), .timer0_src_tick(t0_src),
        .timer0_tick(t0_tick), .device_reset_req(rst_req),
        .osc_driver_en(osc_en), .core_run(core_run), .io_hold(io_hold),
        .prefetch_req(prefetch), .resume_pulse(resume),
        .vector_req(vec_req), .vector_addr(vec_addr));

    // Clock toggles every half period
    always #2.5 core_clk = ~core_clk;

    // Event counters and the hang limit
    always @(posedge core_clk) begin
        cyc++;
        if (rst_req === 1'b1) resets++;
        if (t0_tick === 1'b1) ticks++;
        if (cyc == 30000) begin
            err_total++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (err_total == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Expected status byte from its four flags
    function automatic wdsc_data_t stat(bit oscillator_startup_timer, bit slp, bit tmo_n,
                                        bit pwr_n);
        return {4'h0, oscillator_startup_timer, slp, tmo_n, pwr_n};
    endfunction

    task automatic boot(logic [7:0] f);
        @(posedge core_clk);
        rst_n <= 1'b0;
        fuse_word <= f;
        irq_flag <= 8'h00;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
    endtask

    task automatic wr(wdsc_addr_t a, wdsc_data_t d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(wdsc_addr_t a, wdsc_data_t exp, string what);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 check(what, reg_rdata, exp);
    endtask

    task automatic pulse_clear();
        @(posedge core_clk);
        clear_instr <= 1'b1;
        @(posedge core_clk);
        clear_instr <= 1'b0;
    endtask

    task automatic go_sleep();
        @(posedge core_clk);
        sleep_instr <= 1'b1;
        @(posedge core_clk);
        sleep_instr <= 1'b0;
        #1 check("prefetch_req", prefetch, 1'b1);
    endtask

    // Bounded wait: 0 resume, 1 reset request, 2 oscillator driver
    task automatic wait_for(int which, int lim);
        n = 0;
        do begin
            @(posedge core_clk);
            #1 n++;
        end while (n < lim && (which == 0 ? resume :
                   which == 1 ? rst_req : osc_en) !== 1'b1);
    endtask

    initial begin
        seed = 37919;
        boot(8'h0b);
        rd(`WDSC_OFS_OPTION, `WDSC_OPT_RESET, "option");
        rd(`WDSC_OFS_STATUS, stat(0, 0, 1, 1), "status");
        rd(`WDSC_OFS_GIE, 8'h00, "gie");
        rd(`WDSC_OFS_IRQ_EN, 8'h00, "irq_en");
        rd(8'h14, 8'h00, "unmapped");
        wr(`WDSC_OFS_FUSE, 8'h00);
        rd(`WDSC_OFS_FUSE, 8'h0b, "fuse");
        // Timeout length over random prescaler settings, 1:128 first
        for (i = 0; i < 4; i++) begin
            p = (i == 0) ? 7 : $unsigned($random(seed)) % 8;
            b = (i == 0) ? 1 : $unsigned($random(seed)) % 2;
            wr(`WDSC_OFS_OPTION, {4'h0, b[0], p[2:0]});
            pulse_clear();
            wait_for(1, 2200);
            n0 = b ? BASE << p : BASE;
            check("timeout", n >= n0 - 2 && n <= n0 + 2, 1'b1);
            rd(`WDSC_OFS_STATUS, stat(0, 0, 0, 1), "status tmo");
        end
        // Frequent clears, then a failed oscillator, keep it quiet
        wr(`WDSC_OFS_OPTION, 8'h00);
        r0 = resets;
        repeat (12) begin
            pulse_clear();
            repeat (6) @(posedge core_clk);
        end
        check("clear holds", resets - r0, 0);
        osc_fail <= 1'b1;
        repeat (100) @(posedge core_clk);
        osc_fail <= 1'b0;
        check("osc fail holds", resets - r0, 0);
        boot(8'h03);
        wr(`WDSC_OFS_OPTION, 8'h00);
        repeat (100) @(posedge core_clk);
        check("fuse off", resets - r0, 0);
        // Interrupt wake, inline and vectored
        for (i = 0; i < 2; i++) begin
            b = $unsigned($random(seed)) % 7;
            wr(`WDSC_OFS_GIE, i[7:0]);
            wr(`WDSC_OFS_IRQ_EN, 8'h80 | (8'h01 << b));
            go_sleep();
            check("asleep", {core_run, io_hold, osc_en}, 3'b010);
            rd(`WDSC_OFS_STATUS, stat(0, 1, 1, 0), "status slp");
            // Late enables and bit 7 must not wake the core
            wr(`WDSC_OFS_IRQ_EN, 8'hff);
            irq_flag <= 8'h80 | (8'h01 << ((b + 1) % 7));
            repeat (10) @(posedge core_clk);
            #1 check("no wake", core_run, 1'b0);
            // Drive the wake flag on the edge, not in mid-cycle
            @(posedge core_clk);
            irq_flag <= 8'h01 << b;
            wait_for(0, 4);
            check("wake", n <= 3, 1'b1);
            check("vector", {vec_req, vec_addr}, {i[0], 13'h0004});
            check("running", {core_run, io_hold, osc_en}, 3'b101);
            irq_flag <= 8'h00;
            rd(`WDSC_OFS_STATUS, stat(0, 0, 1, 0), "status woke");
        end
        // Pending enabled flag turns sleep into a no-op only with global enable clear
        boot(8'h03);
        wr(`WDSC_OFS_IRQ_EN, 8'h04);
        irq_flag <= 8'h04;
        go_sleep();
        check("noop run", core_run, 1'b1);
        rd(`WDSC_OFS_STATUS, stat(0, 0, 1, 1), "status noop");
        wr(`WDSC_OFS_GIE, 8'h01);
        go_sleep();
        wait_for(0, 4);
        check("wake at once", {n <= 3, vec_req}, 2'b11);
        rd(`WDSC_OFS_STATUS, stat(0, 0, 1, 0), "status quick");
        // Watchdog wakes a sleeping core without reset
        boot(8'h0b);
        wr(`WDSC_OFS_OPTION, 8'h00);
        r0 = resets;
        go_sleep();
        wait_for(0, 40);
        check("wdt wake", {n <= BASE + 3, resets == r0, vec_req}, 3'b110);
        rd(`WDSC_OFS_STATUS, stat(0, 0, 0, 0), "status wdt");
        wait_for(1, 40);
        check("wake clears", n >= BASE - 6 && n <= BASE, 1'b1);
        // Crystal mode waits for the start-up timer
        boot(8'h09);
        wr(`WDSC_OFS_OPTION, 8'h00);
        r0 = resets;
        go_sleep();
        wait_for(2, 40);
        wait_for(0, 1100);
        check("startup", {n >= 1022 && n <= 1026, resets == r0}, 2'b11);
        // Reset pin while asleep resets the control registers
        boot(8'h03);
        wr(`WDSC_OFS_OPTION, 8'h05);
        go_sleep();
        r0 = resets;
        @(posedge core_clk);
        ext_n <= 1'b0;
        @(posedge core_clk);
        ext_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1 check("pin reset", {resets - r0 == 1, core_run}, 2'b11);
        rd(`WDSC_OFS_OPTION, 8'hff, "option pin");
        // Timer0 sees the prescaler when it is not on the watchdog
        p = $unsigned($random(seed)) % 4;
        wr(`WDSC_OFS_OPTION, {5'h00, p[2:0]});
        r0 = ticks;
        repeat (4 << (p + 1)) begin
            @(posedge core_clk);
            t0_src <= 1'b1;
            @(posedge core_clk);
            t0_src <= 1'b0;
            repeat ($unsigned($random(seed)) % 3) @(posedge core_clk);
        end
        repeat (3) @(posedge core_clk);
        check("timer0 ticks", ticks - r0, 4);
        complete_run();
    end
endmodule // wdsc_core_tb
